// file: rtl/lpc_ctrl.sv
// Low power mode controller with APB registers
//
// What this block does
// - Mode entry needs mode register setup then the sleep instruction.
// - An enabled wake-up interrupt leaves any low power mode.
// - Wake from sleep, clock stop, standby resumes via interrupt.
// - Wake from deep standby restarts through reset processing.
// - Optional units run or halt per their run-enable bit.
// - Halted-retained units are clock gated but stay powered.
// - Halted-undefined units lose power; contents undefined after resume.
// - Output-disable event in clock stop is held, does not wake.
// - Held output-disable interrupt is raised after another wake source.
// - Clock stop halts CPU, RAM, flash, watchdog, peripherals, USB; holds I/O.
// - Deep standby unpowers most units, keeps flash and I/O held.
// - RAM may run in sleep, retained in standby, unpowered deep.
// - Independent watchdog may run except in deep standby.
// - Timers may run in sleep and clock stop, retained in standby.
// - Voltage detector always available, power-on reset always on.
// - Each timer unit pair has a stop bit in stop register A.
// - Error-corrected RAM stop bit in register C; sleep return clock select.
// - Deep standby wake enable, flag and edge registers.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module lpc_ctrl
    import lpc_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sleep_instr,
    input  wire logic                wake_irq,
    input  wire logic                poe_event,
    input  wire logic                poe_irq_en,
    input  wire logic [DSW_W-1:0]    dsw_pin,
    output logic                     poe_irq,
    output logic                     resume_irq,
    output logic                     reset_req,
    output logic [RETCLK_W-1:0]      clk_src,
    output lpc_unit_ctl_t            unit_ctl,
    output lpc_mod_en_t              mod_en,
    output logic                     irq
);

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN, ST_SLEEP, ST_ALLSTOP, ST_SSTBY, ST_DSTBY
    } lpc_state_t;

    // Clock enables per state: the fixed units plus those optional units
    // that software has left enabled; in run everything is clocked
    function automatic logic [10:0] unit_clk(
        input lpc_state_t s,
        input logic [10:0] opt
    );
        unique case (s)
            ST_RUN:     unit_clk = RUN_FIX;
            ST_SLEEP:   unit_clk = SLP_FIX | (SLP_OPT & opt);
            ST_ALLSTOP: unit_clk = AMS_FIX | (AMS_OPT & opt);
            ST_SSTBY:   unit_clk = SSB_FIX | (SSB_OPT & opt);
            ST_DSTBY:   unit_clk = DSB_FIX | (DSB_OPT & opt);
            default:    unit_clk = RUN_FIX;
        endcase
    endfunction

    // Write-one-to-clear with the set side winning
    function automatic logic [31:0] w1c(
        input logic [31:0] cur,
        input logic [31:0] clr,
        input logic [31:0] set
    );
        w1c = (cur & ~clr) | set;
    endfunction

    // -------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------
    lpc_state_t              state_q;
    lpc_state_t              state_d;
    logic [MODE_W-1:0]       mode_q;
    logic [31:0]             stop_a_q;
    logic [31:0]             stop_b_q;
    logic [31:0]             stop_c_q;
    logic [31:0]             stop_d_q;
    logic [7:0]              retclk_q;
    logic [DSW_W-1:0]        dsw_en_q;
    logic [DSW_W-1:0]        dsw_fl_q;
    logic [DSW_W-1:0]        dsw_eg_q;
    logic [DSW_W-1:0]        dsw_prev_q;
    logic [10:0]             optrun_q;
    logic [NIRQ-1:0]         irq_st_q;
    logic [NIRQ-1:0]         irq_mk_q;
    logic                    poe_held_q;
    logic [31:0]             prdata_q;
    logic [31:0]             rdata;
    logic                    hit;

    // Writes land at the access edge; unmapped addresses change nothing
    wire wr    = psel & penable & pwrite;
    wire setup = psel & ~penable;

    wire wr_mode   = wr & (paddr == OFS_MODE);
    wire wr_stop_a = wr & (paddr == OFS_STOP_A);
    wire wr_stop_b = wr & (paddr == OFS_STOP_B);
    wire wr_stop_c = wr & (paddr == OFS_STOP_C);
    wire wr_stop_d = wr & (paddr == OFS_STOP_D);
    wire wr_retclk = wr & (paddr == OFS_RETCLK);
    wire wr_dsw_en = wr & (paddr == OFS_DSW_EN);
    wire wr_dsw_fl = wr & (paddr == OFS_DSW_FL);
    wire wr_dsw_eg = wr & (paddr == OFS_DSW_EG);
    wire wr_optrun = wr & (paddr == OFS_OPTRUN);
    wire wr_irq_st = wr & (paddr == OFS_IRQ_ST);
    wire wr_irq_mk = wr & (paddr == OFS_IRQ_MK);

    // The state word is read-only: a write to it is accepted and dropped
    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        unique case (paddr)
            OFS_MODE:   rdata[MODE_W-1:0] = mode_q;
            OFS_STOP_A: rdata = stop_a_q;
            OFS_STOP_B: rdata = stop_b_q;
            OFS_STOP_C: rdata = stop_c_q;
            OFS_STOP_D: rdata = stop_d_q;
            OFS_RETCLK: rdata[7:0] = retclk_q;
            OFS_DSW_EN: rdata[DSW_W-1:0] = dsw_en_q;
            OFS_DSW_FL: rdata[DSW_W-1:0] = dsw_fl_q;
            OFS_DSW_EG: rdata[DSW_W-1:0] = dsw_eg_q;
            OFS_OPTRUN: rdata[10:0] = optrun_q;
            OFS_STATE:  rdata[2:0] = state_q;
            OFS_IRQ_ST: rdata[NIRQ-1:0] = irq_st_q;
            OFS_IRQ_MK: rdata[NIRQ-1:0] = irq_mk_q;
            default:    hit = 1'b0;
        endcase
    end

    // Zero wait states: read data is captured in the setup phase,
    // so prdata comes from a flop and never ripples with paddr
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup & ~pwrite) begin
            prdata_q <= rdata;
        end
    end

    // -------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q   <= M_SLEEP;
            // Modules start halted: nothing runs before software has
            // configured it and released its stop bit
            stop_a_q <= STOP_RST;
            stop_b_q <= STOP_RST;
            stop_c_q <= STOP_RST;
            stop_d_q <= STOP_RST;
            retclk_q <= RETCLK_RST;
            dsw_en_q <= '0;
            dsw_eg_q <= '0;
            optrun_q <= OPTRUN_RST;
            irq_mk_q <= '0;
        end else begin
            if (wr_mode)   mode_q   <= pwdata[MODE_W-1:0];
            if (wr_stop_a) stop_a_q <= pwdata;
            if (wr_stop_b) stop_b_q <= pwdata;
            if (wr_stop_c) stop_c_q <= pwdata;
            if (wr_stop_d) stop_d_q <= pwdata;
            if (wr_retclk) retclk_q <= pwdata[7:0];
            if (wr_dsw_en) dsw_en_q <= pwdata[DSW_W-1:0];
            if (wr_dsw_eg) dsw_eg_q <= pwdata[DSW_W-1:0];
            if (wr_optrun) optrun_q <= pwdata[10:0];
            if (wr_irq_mk) irq_mk_q <= pwdata[NIRQ-1:0];
        end
    end

    // -------------------------------------------------------------
    // Deep standby wake pins
    // -------------------------------------------------------------
    // Edge select bit one picks the rising edge, zero the falling edge
    // Flags gather edges in every state; only in deep standby do the
    // enabled ones end the mode. Pins are sampled once per clock, so a
    // pulse shorter than a period can go unseen.
    wire [DSW_W-1:0] dsw_rise = dsw_pin & ~dsw_prev_q;
    wire [DSW_W-1:0] dsw_fall = ~dsw_pin & dsw_prev_q;
    wire [DSW_W-1:0] dsw_hit  = (dsw_rise & dsw_eg_q)
                              | (dsw_fall & ~dsw_eg_q);
    wire [DSW_W-1:0] dsw_clr  = wr_dsw_fl ? pwdata[DSW_W-1:0] : '0;
    wire             dsw_wake = |(dsw_fl_q & dsw_en_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsw_prev_q <= '0;
            dsw_fl_q   <= '0;
        end else begin
            dsw_prev_q <= dsw_pin;
            dsw_fl_q   <= (dsw_fl_q & ~dsw_clr) | dsw_hit;
        end
    end

    // -------------------------------------------------------------
    // Mode sequencer
    // -------------------------------------------------------------
    // Entry is taken only in run, so entry and wake never compete. A
    // wake already pending at the entry edge ends the mode one cycle
    // later; software should quiet its wake sources before the instruction.
    wire in_low   = (state_q != ST_RUN);
    wire deep     = (state_q == ST_DSTBY);
    wire do_wake  = in_low & (wake_irq | (deep & dsw_wake));
    wire do_enter = (state_q == ST_RUN) & sleep_instr;

    always_comb begin
        state_d = state_q;
        if (do_enter) begin
            unique case (lpc_mode_t'(mode_q))
                M_SLEEP:   state_d = ST_SLEEP;
                M_ALLSTOP: state_d = ST_ALLSTOP;
                M_SSTBY:   state_d = ST_SSTBY;
                M_DSTBY:   state_d = ST_DSTBY;
            endcase
        end else if (do_wake) begin
            state_d = ST_RUN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_RUN;
            resume_irq <= 1'b0;
            reset_req  <= 1'b0;
            clk_src    <= '0;
        end else begin
            state_q    <= state_d;
            resume_irq <= do_wake & ~deep;
            reset_req  <= do_wake & deep;
            // Only a wake from sleep switches the source; other wakes keep it
            if (do_wake && state_q == ST_SLEEP && retclk_q[RETCLK_EN]) begin
                clk_src <= retclk_q[RETCLK_W-1:0];
            end
        end
    end

    // -------------------------------------------------------------
    // Output-disable interrupt hold
    // -------------------------------------------------------------
    // Held while clocks are stopped so a later wake can deliver it
    // Outside clock stop the source passes through, one pulse a cycle
    // for as long as it stays high; a held event and a live one merge
    wire allstop  = (state_q == ST_ALLSTOP);
    wire poe_src  = poe_event & poe_irq_en;
    wire poe_fire = ~allstop & (poe_held_q | poe_src);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poe_held_q <= 1'b0;
            poe_irq    <= 1'b0;
        end else begin
            if (allstop & poe_src) begin
                poe_held_q <= 1'b1;
            end else if (poe_fire) begin
                poe_held_q <= 1'b0;
            end
            poe_irq <= poe_fire;
        end
    end

    // -------------------------------------------------------------
    // Unit clock, power and module stop gating
    // -------------------------------------------------------------
    wire [10:0] clk_now = unit_clk(state_q, optrun_q);
    wire [10:0] pwr_now = deep ? ~DSB_OFF : 11'h7FF;
    wire        hold_io = (state_q == ST_ALLSTOP)
                        | (state_q == ST_SSTBY) | deep;

    // Module enables follow the peripheral group clock, so a released
    // module still halts with its group in the deeper modes. Timer pairs
    // and the error-corrected RAM follow their own unit clocks instead.
    wire [31:0] per_on = {32{clk_now[U_PER]}};
    wire [31:0] a_en   = ~stop_a_q & per_on;
    wire [31:0] c_en   = ~stop_c_q & per_on;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_ctl <= '{clk_en: RUN_FIX, pwr_en: 11'h7FF, io_hold: 1'b0};
            mod_en   <= '0;
        end else begin
            // Retained units keep power and lose only their clock
            unit_ctl.clk_en  <= clk_now;
            unit_ctl.pwr_en  <= pwr_now;
            unit_ctl.io_hold <= hold_io;
            mod_en.a <= a_en;
            mod_en.a[TMR_HI:TMR_LO] <= ~stop_a_q[TMR_HI:TMR_LO]
                & {4{clk_now[U_TMR]}};
            mod_en.b <= ~stop_b_q & per_on;
            mod_en.c <= c_en;
            mod_en.c[ERROR_CORRECTED_RAM_BIT] <= ~stop_c_q[ERROR_CORRECTED_RAM_BIT]
                & clk_now[U_RAM];
            mod_en.d <= ~stop_d_q & per_on;
        end
    end

    // -------------------------------------------------------------
    // Interrupt status
    // -------------------------------------------------------------
    // Status bits are sticky: an event in the cycle of its clear wins,
    // so software never loses an event by clearing too late
    wire [NIRQ-1:0] ev;
    assign ev[IRQ_WAKE] = do_wake & ~deep;
    assign ev[IRQ_DEEP] = do_wake & deep;
    assign ev[IRQ_POE]  = allstop & poe_src;

    wire [31:0] st_clr = wr_irq_st ? pwdata : 32'h0000_0000;
    wire [31:0] st_nxt = w1c({29'd0, irq_st_q}, st_clr, {29'd0, ev});

    // The interrupt line is a flop fed from the next status, so it
    // moves in the same cycle as the status bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= '0;
            irq      <= 1'b0;
        end else begin
            irq_st_q <= st_nxt[NIRQ-1:0];
            irq      <= |(st_nxt[NIRQ-1:0] & irq_mk_q);
        end
    end

endmodule

`default_nettype wire

// file: rtl/lpc_pkg.sv
// Shared constants and types of the low power mode controller
package lpc_pkg;

    // -------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_MODE   = 8'h00;
    localparam logic [7:0] OFS_STOP_A = 8'h04;
    localparam logic [7:0] OFS_STOP_B = 8'h08;
    localparam logic [7:0] OFS_STOP_C = 8'h0C;
    localparam logic [7:0] OFS_STOP_D = 8'h10;
    localparam logic [7:0] OFS_RETCLK = 8'h14;
    localparam logic [7:0] OFS_DSW_EN = 8'h18;
    localparam logic [7:0] OFS_DSW_FL = 8'h1C;
    localparam logic [7:0] OFS_DSW_EG = 8'h20;
    localparam logic [7:0] OFS_OPTRUN = 8'h24;
    localparam logic [7:0] OFS_STATE  = 8'h28;
    localparam logic [7:0] OFS_IRQ_ST = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MK = 8'h30;

    // -------------------------------------------------------------
    // Fields and reset values
    // -------------------------------------------------------------
    localparam int          MODE_W      = 2;
    localparam int          RETCLK_EN   = 7;
    localparam int          RETCLK_W    = 3;
    localparam int          DSW_W       = 8;
    localparam int          NUNIT       = 11;
    localparam int          NIRQ        = 3;
    localparam int          TMR_LO      = 2;
    localparam int          TMR_HI      = 5;
    localparam int          ERROR_CORRECTED_RAM_BIT  = 6;
    localparam logic [31:0] STOP_RST    = 32'hFFFF_FFFF;
    localparam logic [10:0] OPTRUN_RST  = 11'h7FF;
    localparam logic [7:0]  RETCLK_RST  = 8'h00;

    // Unit indices
    localparam int U_CPU = 0;
    localparam int U_RAM = 1;
    localparam int U_FLS = 2;
    localparam int U_USB = 3;
    localparam int U_WDT = 4;
    localparam int U_IWD = 5;
    localparam int U_POE = 6;
    localparam int U_TMR = 7;
    localparam int U_PER = 8;
    localparam int U_LVD = 9;
    localparam int U_POR = 10;

    // Interrupt status bits
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_DEEP = 1;
    localparam int IRQ_POE  = 2;

    // Per mode: always running, running if enabled, unpowered
    localparam logic [10:0] RUN_FIX  = 11'h7FF;
    localparam logic [10:0] SLP_FIX  = 11'h404;
    localparam logic [10:0] SLP_OPT  = 11'h3EA;
    localparam logic [10:0] AMS_FIX  = 11'h400;
    localparam logic [10:0] AMS_OPT  = 11'h2E0;
    localparam logic [10:0] SSB_FIX  = 11'h400;
    localparam logic [10:0] SSB_OPT  = 11'h220;
    localparam logic [10:0] DSB_FIX  = 11'h400;
    localparam logic [10:0] DSB_OPT  = 11'h200;
    localparam logic [10:0] DSB_OFF  = 11'h1FB;

    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        M_SLEEP, M_ALLSTOP, M_SSTBY, M_DSTBY
    } lpc_mode_t;

    typedef struct packed {
        logic [10:0] clk_en;
        logic [10:0] pwr_en;
        logic        io_hold;
    } lpc_unit_ctl_t;

    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
    } lpc_mod_en_t;

endpackage

// file: tb/lpc_chk.sv
// Port assertions for the low power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpc_chk
    import lpc_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          sleep_instr,
    input wire logic          wake_irq,
    input wire logic          resume_irq,
    input wire logic          reset_req,
    input wire lpc_unit_ctl_t unit_ctl
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Wake and entry steps, per-mode unit clock and power states
    // ----------------------------------------
    sequence s_run_back;
        unit_ctl.clk_en == 11'h7FF && !unit_ctl.io_hold;
    endsequence
    sequence s_one_shot;
        ##1 !resume_irq && !reset_req;
    endsequence
    property p_entry;
        $fell(unit_ctl.clk_en[U_CPU]) |-> $past(sleep_instr, 2);
    endproperty
    a_entry: assert property (p_entry) else $error("cpu clock stopped without instruction");
    property p_wake_src;
        resume_irq |-> $past(wake_irq);
    endproperty
    a_wake_src: assert property (p_wake_src) else $error("resume without wake interrupt");
    property p_resume;
        resume_irq |=> s_run_back;
    endproperty
    a_resume: assert property (p_resume) else $error("units not running after resume");
    property p_restart;
        reset_req |=> unit_ctl.pwr_en == 11'h7FF;
    endproperty
    a_restart: assert property (p_restart) else $error("power not back after restart");
    property p_pulse;
        (resume_irq || reset_req) |-> s_one_shot;
    endproperty
    a_pulse: assert property (p_pulse) else $error("wake indication longer than one cycle");
    property p_kind;
        !(resume_irq && reset_req);
    endproperty
    a_kind: assert property (p_kind) else $error("resume and restart together");
    property p_always;
        unit_ctl.clk_en[U_POR] && unit_ctl.pwr_en[U_LVD] && unit_ctl.pwr_en[U_FLS];
    endproperty
    a_always: assert property (p_always) else $error("always-on unit lost");
    property p_unpowered;
        !unit_ctl.pwr_en[U_CPU] |-> unit_ctl.io_hold && !unit_ctl.clk_en[U_RAM];
    endproperty
    a_unpowered: assert property (p_unpowered) else $error("deep standby state wrong");
    property p_clkstop;
        !unit_ctl.clk_en[U_CPU] && unit_ctl.io_hold |-> !unit_ctl.clk_en[U_USB] && !unit_ctl.clk_en[U_WDT];
    endproperty
    a_clkstop: assert property (p_clkstop) else $error("usb or watchdog clocked in stop");
    property p_retained;
        unit_ctl.pwr_en[U_CPU] |-> unit_ctl.pwr_en == 11'h7FF;
    endproperty
    a_retained: assert property (p_retained) else $error("power lost outside deep standby");
endmodule
bind lpc_ctrl lpc_chk u_chk (.pclk, .presetn, .sleep_instr, .wake_irq, .resume_irq, .reset_req, .unit_ctl);
`default_nettype wire

// file: tb/lpc_cpu_model.sv
// Behavioural CPU and interrupt controller beside the mode controller
`timescale 1ns/1ps
`default_nettype none
module lpc_cpu_model
    import lpc_pkg::*;
#(
    parameter int SVC_DLY = 0
)(
    input  wire logic        pclk,
    input  wire logic        resume_irq,
    input  wire logic        reset_req,
    output logic             sleep_instr,
    output logic             wake_irq,
    output logic             poe_event,
    output logic             poe_irq_en,
    output logic [DSW_W-1:0] dsw_pin
);
    initial begin
        sleep_instr = 1'b0;
        wake_irq = 1'b0;
        poe_event = 1'b0;
        poe_irq_en = 1'b0;
        dsw_pin = '0;
    end
    // Caller programs the mode register first
    task automatic enter();
        @(posedge pclk);
        sleep_instr <= 1'b1;
        @(posedge pclk);
        sleep_instr <= 1'b0;
    endtask
    task automatic wake();
        @(posedge pclk);
        wake_irq <= 1'b1;
    endtask
    task automatic output_disable_logic();
        @(posedge pclk);
        poe_irq_en <= 1'b1;
        poe_event <= 1'b1;
        @(posedge pclk);
        poe_event <= 1'b0;
    endtask
    task automatic pins(input logic [DSW_W-1:0] v);
        @(posedge pclk);
        dsw_pin <= v;
    endtask
    // Request is withdrawn only once serviced, late when SVC_DLY is large
    always @(posedge pclk) begin
        if (resume_irq || reset_req) begin
            repeat (SVC_DLY) @(posedge pclk);
            wake_irq <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: tb/lpc_ctrl_bench.sv
// Self-checking bench for the low power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl_bench
    import lpc_pkg::*;
;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                err, rs, rq, pq, sleep_instr, wake_irq, poe_event, poe_irq_en;
    logic                poe_irq, resume_irq, reset_req, irq;
    logic [DSW_W-1:0]    dsw_pin;
    logic [RETCLK_W-1:0] clk_src;
    lpc_unit_ctl_t       unit_ctl;
    lpc_mod_en_t         mod_en;
    int                  n_fail, cmp_count;
    localparam logic [10:0] EXP_CLK [4] = '{11'h7EE, 11'h6E0, 11'h620, 11'h600};

    lpc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sleep_instr, .wake_irq, .poe_event, .poe_irq_en, .dsw_pin, .poe_irq, .resume_irq,
        .reset_req, .clk_src, .unit_ctl, .mod_en, .irq);
    lpc_cpu_model #(.SVC_DLY(2)) cpu (.pclk, .resume_irq, .reset_req, .sleep_instr, .wake_irq,
        .poe_event, .poe_irq_en, .dsw_pin);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic lp_enter(input int m);
        apb(1'b1, OFS_MODE, 32'(m));
        apb(1'b0, OFS_STATE, '0);
        chk("state before instr", rd, '0);
        cpu.enter();
        apb(1'b0, OFS_STATE, '0);
        chk("state in mode", rd, 32'(m + 1));
    endtask
    // Fixed window wide enough for the wake and the delayed output-disable pulse
    task automatic await_wake();
        rs = 1'b0;
        rq = 1'b0;
        pq = 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            rs = rs | resume_irq;
            rq = rq | reset_req;
            pq = pq | poe_irq;
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        tally_and_finish();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, n_fail, cmp_count} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, OFS_STOP_A + 8'(4 * i), '0);
            chk("stop reset", rd, 32'hFFFF_FFFF);
        end
        chk("mod_en a reset", mod_en.a, '0);
        apb(1'b1, OFS_STOP_A, 32'hFFFF_FFC3);
        apb(1'b1, OFS_STOP_C, 32'hFFFF_FFBF);
        apb(1'b0, OFS_STOP_A, '0);
        chk("stop a", rd, 32'hFFFF_FFC3);
        chk("timer clocks", mod_en.a, 32'h0000_003C);
        chk("ecc ram clock", mod_en.c, 32'h0000_0040);
        apb(1'b1, OFS_STOP_B, '0);
        apb(1'b1, OFS_STOP_D, 32'h0000_FFFF);
        apb(1'b0, OFS_STOP_D, '0);
        chk("stop d", rd, 32'h0000_FFFF);
        chk("module b clocks", mod_en.b, 32'hFFFF_FFFF);
        chk("module d clocks", mod_en.d, 32'hFFFF_0000);
        apb(1'b1, OFS_STOP_A, 32'hFFFF_FFFF);
        apb(1'b1, 8'h34, 32'hFFFF_FFFF);
        chk("unmapped err", 32'(err), 32'h0000_0001);
        apb(1'b0, 8'h34, '0);
        chk("unmapped data", rd, '0);
        chk("timers stopped", mod_en.a, '0);
        $display("module stop test done");
        for (int m = 0; m < 4; m++) begin
            lp_enter(m);
            chk("clk_en", 32'(unit_ctl.clk_en), 32'(EXP_CLK[m]));
            chk("pwr_en", 32'(unit_ctl.pwr_en), m == 3 ? 32'h0000_0604 : 32'h0000_07FF);
            chk("io_hold", 32'(unit_ctl.io_hold), 32'(m != 0));
            chk("periph clocks", mod_en.d, m == 0 ? 32'hFFFF_0000 : 32'h0000_0000);
            cpu.wake();
            await_wake();
            chk("resume", 32'(rs), 32'(m != 3));
            chk("restart", 32'(rq), 32'(m == 3));
            apb(1'b0, OFS_STATE, '0);
            chk("state after wake", rd, '0);
            chk("units after wake", 32'(unit_ctl.clk_en), 32'h0000_07FF);
            chk("periph after wake", mod_en.d, 32'hFFFF_0000);
        end
        apb(1'b0, OFS_IRQ_ST, '0);
        chk("wake status", rd & 32'h0000_0001, 32'h0000_0001);
        chk("irq masked", 32'(irq), '0);
        apb(1'b1, OFS_IRQ_MK, 32'h0000_0001);
        apb(1'b0, OFS_IRQ_ST, '0);
        chk("irq unmasked", 32'(irq), 32'h0000_0001);
        apb(1'b1, OFS_IRQ_ST, 32'h0000_0007);
        apb(1'b0, OFS_IRQ_ST, '0);
        chk("status cleared", rd, '0);
        chk("irq cleared", 32'(irq), '0);
        $display("mode sweep and interrupt test done");
        apb(1'b1, OFS_OPTRUN, '0);
        apb(1'b1, OFS_RETCLK, 32'h0000_0085);
        lp_enter(0);
        chk("optional units off", 32'(unit_ctl.clk_en), 32'h0000_0404);
        cpu.wake();
        await_wake();
        chk("return clock", 32'(clk_src), 32'h0000_0005);
        apb(1'b1, OFS_OPTRUN, 32'h0000_07FF);
        lp_enter(1);
        cpu.output_disable_logic();
        apb(1'b0, OFS_IRQ_ST, '0);
        chk("poe held", rd & 32'h0000_0004, 32'h0000_0004);
        chk("poe irq held back", 32'(poe_irq), '0);
        apb(1'b0, OFS_STATE, '0);
        chk("no wake by poe", rd, 32'h0000_0002);
        cpu.wake();
        await_wake();
        chk("poe irq after wake", 32'(pq), 32'h0000_0001);
        $display("optional run and output-disable test done");
        apb(1'b1, OFS_DSW_EG, 32'h0000_0001);
        apb(1'b1, OFS_DSW_EN, 32'h0000_0001);
        lp_enter(3);
        cpu.pins(8'h01);
        await_wake();
        chk("pin restart", 32'(rq), 32'h0000_0001);
        apb(1'b0, OFS_DSW_FL, '0);
        chk("pin flag", rd, 32'h0000_0001);
        apb(1'b1, OFS_DSW_FL, 32'h0000_0001);
        apb(1'b0, OFS_DSW_FL, '0);
        chk("pin flag cleared", rd, '0);
        apb(1'b1, OFS_DSW_EG, '0);
        lp_enter(3);
        cpu.pins(8'h00);
        await_wake();
        chk("fall restart", 32'(rq), 32'h0000_0001);
        $display("deep standby pin wake test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
